// file: pin_select_checker.sv
/* Assertions for the pin function select block.
   Bound to the top module and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none

module pin_select_checker (
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic PIN_IN,
   input wire logic PIN_OE,
   input wire logic PIN_PULL_UP,
   input wire logic ANALOG_EXTEND_INPUT_EN,
   input wire logic PORT_IN_DATA,
   input wire logic [2:0] PIN_FUNCTION
);
   // ---------------------------------------------
   // Pad and bus relations
   // ---------------------------------------------
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);
   wire logic [2:0] f = PIN_FUNCTION;
   wire logic oe = PIN_OE;
   wire logic pu = PIN_PULL_UP;
   wire logic an = ANALOG_EXTEND_INPUT_EN;
   a_port_out_drive: assert property (f == 3'h2 |-> oe && !pu && !an) else $error("port out");
   a_plain_input: assert property (f == 3'h0 |-> !oe && !pu && !an) else $error("plain in");
   a_pulled_input: assert property (f == 3'h1 |-> !oe && pu && !an) else $error("pulled in");
   a_analog_route: assert property (f == 3'h3 |-> an && !oe && !pu) else $error("analog");
   a_serial_drive: assert property (f == 3'h4 |-> oe && !pu && !an) else $error("serial");
   a_serial_float: assert property (f == 3'h5 |-> !oe && !pu && !an) else $error("float");
   a_undefined_safe: assert property (f == 3'h6 |-> !oe && !pu && !an) else $error("undefined");
   a_input_copy: assert property ($past(RESETN) |-> PORT_IN_DATA == $past(PIN_IN)) else $error("pad in");
   a_ready_pulse: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY) else $error("ready");
   a_error_ready: assert property ($rose(PSLVERR) |-> PREADY) else $error("error timing");
   c_analog: cover property (f == 3'h3);
   c_serial: cover property (f == 3'h4);
   c_error: cover property (PSLVERR);
   c_undefined: cover property (f == 3'h6);
endmodule // pin_select_checker

bind port_pin_function_select pin_select_checker i_chk (.CORE_CLK, .RESETN, .PSEL, .PENABLE,
   .PREADY, .PSLVERR, .PIN_IN, .PIN_OE, .PIN_PULL_UP, .ANALOG_EXTEND_INPUT_EN, .PORT_IN_DATA,
   .PIN_FUNCTION);

`default_nettype wire

// file: pin_select_pkg.sv
/*
 Constants for the port pin function select block: register offsets,
 field positions, reset values and the pin function codes.
 Assumes a 32-bit APB with byte addresses; no reset values are given,
 so every register starts at zero (port input, no pull-up).
*/
`default_nettype none

package pin_select_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   // Some offsets are not multiples of four, so all of them are indices
   localparam logic [9:0] SERIAL_CHANNEL_CONTROL_IDX = 10'h366;
   localparam logic [9:0] ANALOG_CONTROL_ONE_IDX = 10'h3D7;
   localparam logic [9:0] PORT_DIRECTION_IDX = 10'h3F3;
   localparam logic [9:0] PULL_UP_CONTROL_IDX = 10'h3FE;
   localparam int ADDR_W = 12;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int DIR_BIT = 6;
   localparam int PULL_BIT = 3;
   localparam int OPAMP_HI_BIT = 7;
   localparam int OPAMP_LO_BIT = 6;
   localparam int SEL_BIT = 3;
   localparam int ODIS_BIT = 2;

   // ----------------------------------------------------------------
   // Reset values and widths
   // ----------------------------------------------------------------
   localparam int REG_W = 8;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Pin function codes shown on the status output
   typedef enum logic [2:0] {
      FN_PORT_IN,
      FN_PORT_IN_PULL,
      FN_PORT_OUT,
      FN_ANALOG,
      FN_SERIAL_OUT,
      FN_SERIAL_HIZ,
      FN_UNDEFINED
   } pin_function_e;

endpackage

`default_nettype wire

// file: port_pin_function_select.sv
/*
 Function select for one multiplexed port pin, with its four control
 registers on an APB slave.
 Assumes the serial shifter, analog converter and pad sit outside; pad
 inputs are synchronous to CORE_CLK.
*/
`timescale 1ns/100ps
`default_nettype none

module port_pin_function_select (
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic PORT_OUT_DATA,
   input wire logic SERIAL_DATA_OUT,
   input wire logic PIN_IN,
   output logic PIN_OUT,
   output logic PIN_OE,
   output logic PIN_PULL_UP,
   output logic ANALOG_EXTEND_INPUT_EN,
   output logic PORT_IN_DATA,
   output logic [2:0] PIN_FUNCTION
);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [7:0] serial_channel_control_reg;
   logic [7:0] analog_control_one_reg;
   logic [7:0] port_direction_reg;
   logic [7:0] pull_up_control_reg;

   // Decode a byte address onto one of the four register indices.
   // Each register sits at four times its index, so the two low address
   // bits must be zero; any other address answers with an error.
   // Code 4 means no register was hit.
   function automatic logic [2:0] decode(input logic [11:0] addr);
      logic [2:0] sel;
      sel = 3'h4;
      if (addr == {pin_select_pkg::SERIAL_CHANNEL_CONTROL_IDX, 2'b00}) begin
         sel = 3'h0;
      end else if (addr == {pin_select_pkg::ANALOG_CONTROL_ONE_IDX, 2'b00}) begin
         sel = 3'h1;
      end else if (addr == {pin_select_pkg::PORT_DIRECTION_IDX, 2'b00}) begin
         sel = 3'h2;
      end else if (addr == {pin_select_pkg::PULL_UP_CONTROL_IDX, 2'b00}) begin
         sel = 3'h3;
      end
      return sel;
   endfunction

   logic [2:0] bus_sel;
   logic setup_phase;
   logic wr_en;

   assign bus_sel = decode(PADDR);
   assign setup_phase = PSEL && !PENABLE;
   // Writes land in the access cycle, when PREADY is high
   // A cleared PSTRB[0] drops the write quietly, with no error
   assign wr_en = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && (bus_sel != 3'h4);

   // ----------------------------------------------------------------
   // Bus answer
   // ----------------------------------------------------------------
   // No wait state: PREADY rises in the first access cycle, so every
   // transfer takes exactly two cycles and the master never stalls longer
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         PREADY <= 1'b0;
      end else begin
         PREADY <= setup_phase;
      end
   end

   // Read data and error answer, captured in the setup cycle
   // Capturing early keeps PRDATA a plain flip-flop output
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         PRDATA <= 32'h00000000;
         PSLVERR <= 1'b0;
      end else if (setup_phase) begin
         PSLVERR <= (bus_sel == 3'h4);
         if (PWRITE) begin
            PRDATA <= 32'h00000000;
         end else if (bus_sel == 3'h0) begin
            PRDATA <= {24'h000000, serial_channel_control_reg};
         end else if (bus_sel == 3'h1) begin
            PRDATA <= {24'h000000, analog_control_one_reg};
         end else if (bus_sel == 3'h2) begin
            PRDATA <= {24'h000000, port_direction_reg};
         end else if (bus_sel == 3'h3) begin
            PRDATA <= {24'h000000, pull_up_control_reg};
         end else begin
            PRDATA <= 32'h00000000;
         end
      end else if (!PSEL) begin
         PSLVERR <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // Only the low byte lane is stored; every register is eight bits wide
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         serial_channel_control_reg <= pin_select_pkg::REG_RESET;
         analog_control_one_reg <= pin_select_pkg::REG_RESET;
         port_direction_reg <= pin_select_pkg::REG_RESET;
         pull_up_control_reg <= pin_select_pkg::REG_RESET;
      end else if (wr_en) begin
         if (bus_sel == 3'h0) begin
            serial_channel_control_reg <= PWDATA[7:0];
         end else if (bus_sel == 3'h1) begin
            analog_control_one_reg <= PWDATA[7:0];
         end else if (bus_sel == 3'h2) begin
            port_direction_reg <= PWDATA[7:0];
         end else begin
            pull_up_control_reg <= PWDATA[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Function selection
   // ----------------------------------------------------------------
   logic dir_b;
   logic pull_b;
   logic op_hi_b;
   logic op_lo_b;
   logic sel_b;
   logic odis_b;
   pin_select_pkg::pin_function_e fn;

   assign dir_b = port_direction_reg[pin_select_pkg::DIR_BIT];
   assign pull_b = pull_up_control_reg[pin_select_pkg::PULL_BIT];
   assign op_hi_b = analog_control_one_reg[pin_select_pkg::OPAMP_HI_BIT];
   assign op_lo_b = analog_control_one_reg[pin_select_pkg::OPAMP_LO_BIT];
   assign sel_b = serial_channel_control_reg[pin_select_pkg::SEL_BIT];
   assign odis_b = serial_channel_control_reg[pin_select_pkg::ODIS_BIT];

   // Priority: serial select first, then analog, then port
   // Any combination outside the listed ones falls to the undefined code,
   // so an unlisted setting never drives the pin or turns on the pull-up;
   // a half-programmed setting that forms a listed combination is applied like a finished one
   always_comb begin
      fn = pin_select_pkg::FN_UNDEFINED;
      if (sel_b) begin
         if (!dir_b && !pull_b && !op_hi_b && !op_lo_b) begin
            // Disable bit matters only here
            if (odis_b) begin
               fn = pin_select_pkg::FN_SERIAL_HIZ;
            end else begin
               fn = pin_select_pkg::FN_SERIAL_OUT;
            end
         end
      end else if (op_hi_b || op_lo_b) begin
         if (op_hi_b && !op_lo_b && !dir_b && !pull_b) begin
            fn = pin_select_pkg::FN_ANALOG;
         end
      end else if (dir_b) begin
         fn = pin_select_pkg::FN_PORT_OUT;
      end else if (pull_b) begin
         fn = pin_select_pkg::FN_PORT_IN_PULL;
      end else begin
         fn = pin_select_pkg::FN_PORT_IN;
      end
   end

   // ----------------------------------------------------------------
   // Pad controls
   // ----------------------------------------------------------------
   // Pad controls, all registered; undefined combinations float the pin
   // The registered stage costs one cycle after a register write
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         PIN_OUT <= 1'b0;
         PIN_OE <= 1'b0;
         PIN_PULL_UP <= 1'b0;
         ANALOG_EXTEND_INPUT_EN <= 1'b0;
         PIN_FUNCTION <= 3'h0;
      end else begin
         PIN_FUNCTION <= fn;
         PIN_OE <= (fn == pin_select_pkg::FN_PORT_OUT) ||
                   (fn == pin_select_pkg::FN_SERIAL_OUT);
         PIN_OUT <= (fn == pin_select_pkg::FN_SERIAL_OUT) ? SERIAL_DATA_OUT
                                                          : PORT_OUT_DATA;
         PIN_PULL_UP <= (fn == pin_select_pkg::FN_PORT_IN_PULL);
         ANALOG_EXTEND_INPUT_EN <= (fn == pin_select_pkg::FN_ANALOG);
      end
   end

   // ----------------------------------------------------------------
   // Pad input
   // ----------------------------------------------------------------
   // Port input data seen by the core
   // The pad is taken as synchronous to the clock, so one flop is enough;
   // it is sampled whatever function the pin has
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         PORT_IN_DATA <= 1'b0;
      end else begin
         PORT_IN_DATA <= PIN_IN;
      end
   end

endmodule // port_pin_function_select

`default_nettype wire

// file: tb_top.sv
/* Self-checking bench for the pin function select block.
   Drives APB and the pad inputs itself; no far-side model. */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   // ---------------------------------------------
   // Signals and design
   // ---------------------------------------------
   logic CORE_CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   logic PIN_OUT, PIN_OE, PIN_PULL_UP, ANALOG_EXTEND_INPUT_EN, PORT_IN_DATA;
   logic PORT_OUT_DATA, SERIAL_DATA_OUT, PIN_IN;
   logic [2:0] PIN_FUNCTION;
   logic [11:0] adr [4];
   logic [39:0] tbl [8];
   int err_count = 0;
   int tests_run = 0;

   port_pin_function_select i_dut (.CORE_CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR,
      .PWDATA, .PSTRB(4'hF), .PRDATA, .PREADY, .PSLVERR, .PORT_OUT_DATA,
      .SERIAL_DATA_OUT, .PIN_IN, .PIN_OUT, .PIN_OE, .PIN_PULL_UP,
      .ANALOG_EXTEND_INPUT_EN, .PORT_IN_DATA, .PIN_FUNCTION);

   // One APB transfer: setup, then access until ready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      @(posedge CORE_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      do @(posedge CORE_CLK); while (PREADY !== 1'b1);
      r = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   initial begin
      CORE_CLK = 1'b0;
      forever #5 CORE_CLK = ~CORE_CLK;
   end

   // Watchdog against a hung handshake
   initial begin
      repeat (5000) @(posedge CORE_CLK);
      err_count++;
      summarize();
   end

   // Table: direction, pull-up, analog, serial register values, then function code
   initial begin
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 12'h000;
      PWDATA = 32'h0;
      PORT_OUT_DATA = 1'b0;
      SERIAL_DATA_OUT = 1'b0;
      PIN_IN = 1'b0;
      RESETN = 1'b0;
      adr = '{{pin_select_pkg::PORT_DIRECTION_IDX, 2'b00}, {pin_select_pkg::PULL_UP_CONTROL_IDX,
         2'b00}, {pin_select_pkg::ANALOG_CONTROL_ONE_IDX, 2'b00},
         {pin_select_pkg::SERIAL_CHANNEL_CONTROL_IDX, 2'b00}};
      tbl = '{40'h0000000000, 40'h0000000400, 40'h0008000001, 40'h4008000002,
         40'h0000800003, 40'h0000000804, 40'h0000000C05, 40'h4000000402};
      repeat (16) @(posedge CORE_CLK);
      RESETN <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, adr[i], 32'h0, rd, er);
         chk("reset value", 32'h0, rd);
      end
      for (int i = 0; i < 8; i++) begin
         for (int j = 0; j < 4; j++) apb(1'b1, adr[j], tbl[i][39-8*j -: 8], rd, er);
         for (int j = 0; j < 4; j++) begin
            apb(1'b0, adr[j], 32'h0, rd, er);
            chk("readback", tbl[i][39-8*j -: 8], rd);
         end
         // Both levels on the pad data inputs, so a swapped source shows
         for (int k = 0; k < 2; k++) begin
            PORT_OUT_DATA <= k[0];
            SERIAL_DATA_OUT <= !k[0];
            PIN_IN <= k[0];
            repeat (2) @(posedge CORE_CLK);
            chk("function", tbl[i][2:0], PIN_FUNCTION);
            chk("drive", tbl[i][2:0] inside {3'h2, 3'h4}, PIN_OE);
            chk("pull", tbl[i][2:0] == 3'h1, PIN_PULL_UP);
            chk("analog", tbl[i][2:0] == 3'h3, ANALOG_EXTEND_INPUT_EN);
            chk("pad input", k, PORT_IN_DATA);
            if (tbl[i][2:0] == 3'h2) chk("port data", k, PIN_OUT);
            if (tbl[i][2:0] == 3'h4) chk("serial data", !k[0], PIN_OUT);
         end
      end
      // Both op-amp bits set is not a listed combination: pin must stay quiet
      apb(1'b1, adr[2], 32'h000000C0, rd, er);
      repeat (2) @(posedge CORE_CLK);
      chk("undefined function", 32'h6, PIN_FUNCTION);
      chk("undefined drive", 32'h0, PIN_OE);
      // Reset in mid-run clears registers and pad controls
      RESETN <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      RESETN <= 1'b1;
      apb(1'b0, adr[2], 32'h0, rd, er);
      chk("reset again", 32'h0, rd);
      chk("function after reset", 32'h0, PIN_FUNCTION);
      chk("drive after reset", 32'h0, PIN_OE);
      apb(1'b0, 12'h000, 32'h0, rd, er);
      chk("unmapped error", 32'h1, er);
      chk("unmapped data", 32'h0, rd);
      summarize();
   end
endmodule // tb_top

`default_nettype wire
